/* rtl/dtc_regs.svh */
// register indices, field positions, reset values and timing counts of the dual timer/counter
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// register indices; byte address is four times the index
`define DTC_IDX_CTRL        10'h088
`define DTC_IDX_MODE        10'h089
`define DTC_IDX_A_LOW       10'h08a
`define DTC_IDX_B_LOW       10'h08b
`define DTC_IDX_A_HIGH      10'h08c
`define DTC_IDX_B_HIGH      10'h08d
`define DTC_IDX_AUX         10'h08f

// timer_control_reg fields
`define DTC_CTRL_B_OVF      7
`define DTC_CTRL_B_RUN      6
`define DTC_CTRL_A_OVF      5
`define DTC_CTRL_A_RUN      4

// timer_mode_reg: timer b in bits 7:4, timer a in bits 3:0
`define DTC_MODE_B_LSB      4
`define DTC_MODE_A_LSB      0
`define DTC_NIB_GATE        3
`define DTC_NIB_SRC         2

// aux register: half-clock rate for baud and clock-out usage
`define DTC_AUX_A_FAST      0
`define DTC_AUX_B_FAST      1

// reset values
`define DTC_CTRL_RST        8'h00
`define DTC_MODE_RST        8'h00
`define DTC_COUNT_RST       8'h00
`define DTC_AUX_RST         8'h00

// timing: system clocks per peripheral cycle and the phases in it
`define DTC_PERIPH_DIV      12
`define DTC_SAMPLE_PHASE    4'h9
`define DTC_UPDATE_PHASE    4'h4

`endif

/* rtl/dtc_pkg.sv */
// types shared by the dual timer/counter
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE13  = 2'b00,
    DTC_MODE16  = 2'b01,
    DTC_RELOAD8 = 2'b10,
    DTC_SPLIT   = 2'b11
  } dtc_mode_t;

endpackage

/* rtl/dtc_timer.sv */
// one timer/counter: count bytes, mode datapath and overflow pulses
`timescale 1ns/10ps
`default_nettype none
`include "dtc_regs.svh"

module dtc_timer
  import dtc_pkg::*;
#(
  parameter bit SPLIT = 1'b0
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // control
  input  wire dtc_mode_t  mode,
  input  wire logic       inc_low,
  input  wire logic       inc_high,
  // software writes
  input  wire logic       wr_low,
  input  wire logic       wr_high,
  input  wire logic [7:0] wdata,
  // state
  output logic      [7:0] count_low_byte,
  output logic      [7:0] count_high_byte,
  output logic            ovf_main_r,
  output logic            ovf_high_r
);

  logic [7:0] low_nxt;
  logic [7:0] high_nxt;
  logic       ovf_main_nxt;
  logic       ovf_high_nxt;

  always_comb
  begin
    low_nxt      = count_low_byte;
    high_nxt     = count_high_byte;
    ovf_main_nxt = 1'b0;
    ovf_high_nxt = 1'b0;
    case (mode)
      DTC_MODE13:
      begin
        if (inc_low)
        begin
          // five-bit prescaler, upper three bits left alone
          low_nxt = {count_low_byte[7:5], count_low_byte[4:0] + 5'h01};
          if (count_low_byte[4:0] == 5'h1f)
          begin
            high_nxt     = count_high_byte + 8'h01;
            ovf_main_nxt = (count_high_byte == 8'hff);
          end
        end
      end
      DTC_MODE16:
      begin
        if (inc_low)
        begin
          low_nxt = count_low_byte + 8'h01;
          if (count_low_byte == 8'hff)
          begin
            high_nxt     = count_high_byte + 8'h01;
            ovf_main_nxt = (count_high_byte == 8'hff);
          end
        end
      end
      DTC_RELOAD8:
      begin
        if (inc_low)
        begin
          if (count_low_byte == 8'hff)
          begin
            low_nxt      = count_high_byte;
            ovf_main_nxt = 1'b1;
          end
          else
          begin
            low_nxt = count_low_byte + 8'h01;
          end
        end
      end
      default:
      begin
        // split into two 8-bit timers, or hold when not split
        if (SPLIT)
        begin
          if (inc_low)
          begin
            low_nxt      = count_low_byte + 8'h01;
            ovf_main_nxt = (count_low_byte == 8'hff);
          end
          if (inc_high)
          begin
            high_nxt     = count_high_byte + 8'h01;
            ovf_high_nxt = (count_high_byte == 8'hff);
          end
        end
      end
    endcase
  end

  // a software write wins over counting in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count_low_byte  <= `DTC_COUNT_RST;
      count_high_byte <= `DTC_COUNT_RST;
    end
    else
    begin
      count_low_byte  <= wr_low ? wdata : low_nxt;
      count_high_byte <= wr_high ? wdata : high_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ovf_main_r <= 1'b0;
      ovf_high_r <= 1'b0;
    end
    else
    begin
      ovf_main_r <= ovf_main_nxt & ~wr_low;
      ovf_high_r <= ovf_high_nxt & ~wr_high;
    end
  end

endmodule // dtc_timer

`default_nettype wire

/* rtl/dtc_top.sv */
// dual timer/counter with wishbone register access
// Notes on behaviour
// - in 16-bit mode low byte carry bumps high byte; high carry sets overflow.
// - starting the run bit keeps count bytes; counting resumes from them.
// - source 0 counts peripheral cycles; source 1 counts count-pin falling edges.
// - baud and clock-out usage counts at half the system clock.
// - pin sampled once per peripheral cycle; high then low counts at update phase.
// - one falling edge needs two peripheral cycles; max rate clock over 24.
// - gate 0 means run alone enables; gate 1 adds the interrupt pin.
// - rollover from all ones to zero sets overflow flag and requests interrupt.
// - mode 0 is 13-bit: five-bit prescaler feeding high byte.
// - mode 2 reloads low byte from high byte on overflow and flags.
// - servicing a timer interrupt clears its overflow flag by hardware.
// - mode 3 splits timer a; high byte uses timer b run and flag.
// - timer b in mode 3 halts and holds its count.
// - timer a uses mode bits 3:0 and control bits 0, 1, 4, 5.
// - timer b uses mode bits 7:4 and control bits 2, 3, 6, 7.
// - timer b supplies the serial rate, best in auto-reload mode.
// - mode bits 00, 01, 10, 11 select 13-bit, 16-bit, reload, mode 3.
// - with gating, counting needs interrupt pin high and run bit set.
// - control, mode and count registers all reset to zero.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_regs.svh"

module dtc_top
  import dtc_pkg::*;
#(
  parameter int PERIPH_DIV = `DTC_PERIPH_DIV
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // external pins
  input  wire logic        count_pin_a,
  input  wire logic        count_pin_b,
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  // interrupt service acknowledges
  input  wire logic        int_service_a,
  input  wire logic        int_service_b,
  // interrupt requests and serial rate pulse
  output logic             irq_a,
  output logic             irq_b,
  output logic             serial_rate_pulse
);

  logic [7:0]  timer_control_reg;
  logic [7:0]  timer_mode_reg;
  logic [7:0]  aux_r;
  logic [3:0]  phase_r;
  logic        periph_tick;
  logic        sample_tick;
  logic        half_tick_r;
  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  logic [1:0]  samp_r;
  logic [1:0]  pend_r;
  logic        bus_req;
  logic        bus_wr;
  logic [9:0]  idx;
  logic [7:0]  rdata;
  logic        wr_ctrl;
  logic        wr_mode;
  logic [3:0]  nib_a;
  logic [3:0]  nib_b;
  logic        a_split;
  logic        run_a;
  logic        run_b;
  logic        en_a;
  logic        en_b;
  logic        tick_a;
  logic        tick_b;
  logic        inc_a_low;
  logic        inc_b_low;
  logic        inc_a_high;
  logic [7:0]  a_low;
  logic [7:0]  a_high;
  logic [7:0]  b_low;
  logic [7:0]  b_high;
  logic        a_ovf;
  logic        a_ovf_high;
  logic        b_ovf;
  logic        set_a;
  logic        set_b;
  logic        clr_a;
  logic        clr_b;

  // peripheral cycle divider and phases
  always_ff @(posedge clk)
  begin
    if (srst)
      phase_r <= 4'h0;
    else if (phase_r == 4'(PERIPH_DIV - 1))
      phase_r <= 4'h0;
    else
      phase_r <= phase_r + 4'h1;
  end

  assign periph_tick = (phase_r == `DTC_UPDATE_PHASE);
  assign sample_tick = (phase_r == `DTC_SAMPLE_PHASE);

  // half system clock rate enable
  always_ff @(posedge clk)
  begin
    if (srst)
      half_tick_r <= 1'b0;
    else
      half_tick_r <= ~half_tick_r;
  end

  // two-stage synchronisers: {irq_b, irq_a, count_b, count_a}
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end
    else
    begin
      sync1_r <= {ext_irq_b_pin, ext_irq_a_pin, count_pin_b, count_pin_a};
      sync2_r <= sync1_r;
    end
  end

  // falling edge seen at the sample phase, counted at the update phase
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      samp_r <= 2'b00;
      pend_r <= 2'b00;
    end
    else
    begin
      if (sample_tick)
      begin
        samp_r <= sync2_r[1:0];
        pend_r <= pend_r | (samp_r & ~sync2_r[1:0]);
      end
      else if (periph_tick)
      begin
        pend_r <= 2'b00;
      end
    end
  end

  // wishbone decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign idx     = wb_adr_i[11:2];
  assign wr_ctrl = bus_wr & (idx == `DTC_IDX_CTRL);
  assign wr_mode = bus_wr & (idx == `DTC_IDX_MODE);

  always_comb
  begin
    if (idx == `DTC_IDX_CTRL)
      rdata = timer_control_reg;
    else if (idx == `DTC_IDX_MODE)
      rdata = timer_mode_reg;
    else if (idx == `DTC_IDX_A_LOW)
      rdata = a_low;
    else if (idx == `DTC_IDX_A_HIGH)
      rdata = a_high;
    else if (idx == `DTC_IDX_B_LOW)
      rdata = b_low;
    else if (idx == `DTC_IDX_B_HIGH)
      rdata = b_high;
    else if (idx == `DTC_IDX_AUX)
      rdata = aux_r;
    else
      rdata = 8'h00;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req)
        wb_dat_o <= {24'h00_0000, rdata};
    end
  end

  // mode and aux registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      timer_mode_reg <= `DTC_MODE_RST;
      aux_r          <= `DTC_AUX_RST;
    end
    else
    begin
      if (wr_mode)
        timer_mode_reg <= wb_dat_i[7:0];
      if (bus_wr && idx == `DTC_IDX_AUX)
        aux_r <= wb_dat_i[7:0] & 8'h03;
    end
  end

  // control register; overflow set wins over any clear
  assign clr_a = int_service_a | (wr_ctrl & ~wb_dat_i[`DTC_CTRL_A_OVF]);
  assign clr_b = int_service_b | (wr_ctrl & ~wb_dat_i[`DTC_CTRL_B_OVF]);
  assign set_a = a_ovf | (wr_ctrl & wb_dat_i[`DTC_CTRL_A_OVF]);
  assign set_b = (b_ovf & ~a_split) | a_ovf_high | (wr_ctrl & wb_dat_i[`DTC_CTRL_B_OVF]);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      timer_control_reg <= `DTC_CTRL_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        timer_control_reg[`DTC_CTRL_B_RUN] <= wb_dat_i[`DTC_CTRL_B_RUN];
        timer_control_reg[`DTC_CTRL_A_RUN] <= wb_dat_i[`DTC_CTRL_A_RUN];
        timer_control_reg[3:0]             <= wb_dat_i[3:0];
      end
      if (set_a)
        timer_control_reg[`DTC_CTRL_A_OVF] <= 1'b1;
      else if (clr_a)
        timer_control_reg[`DTC_CTRL_A_OVF] <= 1'b0;
      if (set_b)
        timer_control_reg[`DTC_CTRL_B_OVF] <= 1'b1;
      else if (clr_b)
        timer_control_reg[`DTC_CTRL_B_OVF] <= 1'b0;
    end
  end

  // per-timer control fields
  assign nib_a   = timer_mode_reg[`DTC_MODE_A_LSB +: 4];
  assign nib_b   = timer_mode_reg[`DTC_MODE_B_LSB +: 4];
  assign a_split = (dtc_mode_t'(nib_a[1:0]) == DTC_SPLIT);
  assign run_a   = timer_control_reg[`DTC_CTRL_A_RUN];
  // timer b run bit belongs to timer a high byte while split
  assign run_b   = a_split | timer_control_reg[`DTC_CTRL_B_RUN];

  assign en_a = run_a & (~nib_a[`DTC_NIB_GATE] | sync2_r[2]);
  assign en_b = run_b & (~nib_b[`DTC_NIB_GATE] | sync2_r[3]);

  // count source: pin edge, peripheral cycle or half clock
  assign tick_a = nib_a[`DTC_NIB_SRC] ? (pend_r[0] & periph_tick)
                : (aux_r[`DTC_AUX_A_FAST] ? half_tick_r : periph_tick);
  assign tick_b = nib_b[`DTC_NIB_SRC] ? (pend_r[1] & periph_tick)
                : (aux_r[`DTC_AUX_B_FAST] ? half_tick_r : periph_tick);

  assign inc_a_low  = tick_a & en_a;
  assign inc_b_low  = tick_b & en_b & (dtc_mode_t'(nib_b[1:0]) != DTC_SPLIT);
  assign inc_a_high = periph_tick & timer_control_reg[`DTC_CTRL_B_RUN];

  dtc_timer #(
    .SPLIT           (1'b1)
  ) u_timer_a (
    .clk             (clk),
    .srst            (srst),
    .mode            (dtc_mode_t'(nib_a[1:0])),
    .inc_low         (inc_a_low),
    .inc_high        (inc_a_high),
    .wr_low          (bus_wr && idx == `DTC_IDX_A_LOW),
    .wr_high         (bus_wr && idx == `DTC_IDX_A_HIGH),
    .wdata           (wb_dat_i[7:0]),
    .count_low_byte  (a_low),
    .count_high_byte (a_high),
    .ovf_main_r      (a_ovf),
    .ovf_high_r      (a_ovf_high)
  );

  dtc_timer #(
    .SPLIT           (1'b0)
  ) u_timer_b (
    .clk             (clk),
    .srst            (srst),
    .mode            (dtc_mode_t'(nib_b[1:0])),
    .inc_low         (inc_b_low),
    .inc_high        (1'b0),
    .wr_low          (bus_wr && idx == `DTC_IDX_B_LOW),
    .wr_high         (bus_wr && idx == `DTC_IDX_B_HIGH),
    .wdata           (wb_dat_i[7:0]),
    .count_low_byte  (b_low),
    .count_high_byte (b_high),
    .ovf_main_r      (b_ovf),
    .ovf_high_r      ()
  );

  // interrupt requests and serial rate pulse
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_a             <= 1'b0;
      irq_b             <= 1'b0;
      serial_rate_pulse <= 1'b0;
    end
    else
    begin
      irq_a             <= set_a | (timer_control_reg[`DTC_CTRL_A_OVF] & ~clr_a);
      irq_b             <= set_b | (timer_control_reg[`DTC_CTRL_B_OVF] & ~clr_b);
      serial_rate_pulse <= b_ovf;
    end
  end

endmodule // dtc_top

`default_nettype wire

/* tb/dtc_pin_model.sv */
// count and gate pin model standing outside the timer block
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model #(
  parameter int HOLD = 24
)
(
  // clock and command
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] edges,
  input  wire logic [1:0] gate_lvl,
  // pins
  output logic            count_a,
  output logic            count_b,
  output logic            gate_a,
  output logic            gate_b,
  output logic            busy
);
  logic [8:0] phase_r = 9'h000;
  logic [7:0] tick_r  = 8'h00;
  logic       pin_r   = 1'b1;

  // each level held two peripheral cycles, idle high
  always @(posedge clk)
  begin
    if (go && phase_r == 9'h000)
    begin
      phase_r <= {edges, 1'b0};
      tick_r  <= 8'h00;
    end
    else if (phase_r != 9'h000)
    begin
      if (tick_r == 8'(HOLD - 1))
      begin
        tick_r  <= 8'h00;
        phase_r <= phase_r - 9'h001;
        pin_r   <= ~pin_r;
      end
      else
        tick_r <= tick_r + 8'h01;
    end
  end

  assign count_a = pin_r;
  assign count_b = pin_r;
  assign gate_a  = gate_lvl[0];
  assign gate_b  = gate_lvl[1];
  assign busy    = phase_r != 9'h000;
endmodule // dtc_pin_model
`default_nettype wire

/* tb/dtc_top_monitor.sv */
// port-level assertions for the dual timer/counter
`timescale 1ns/10ps
`default_nettype none
module dtc_top_monitor (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        int_service_a,
  input wire logic        int_service_b,
  input wire logic        irq_a,
  input wire logic        irq_b,
  input wire logic        serial_rate_pulse
);
  logic ctrl_wr;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  assign ctrl_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 12'h220;

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // request up, then a cycle with no service pulse and no control write
  sequence s_a_kept;
    irq_a ##1 (irq_a && !int_service_a && !ctrl_wr);
  endsequence
  sequence s_b_kept;
    irq_b ##1 (irq_b && !int_service_b && !ctrl_wr);
  endsequence

  a_ack_one_late: assert property (s_take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_irq_a_held: assert property (s_a_kept |=> irq_a)
    else $error("irq a dropped without service");
  a_irq_b_held: assert property (s_b_kept |=> irq_b)
    else $error("irq b dropped without service");
  a_irq_a_cleared: assert property ($fell(irq_a) && !$past(srst) |-> $past(int_service_a) || $past(ctrl_wr))
    else $error("irq a fell with no cause");
  a_irq_b_cleared: assert property ($fell(irq_b) && !$past(srst) |-> $past(int_service_b) || $past(ctrl_wr))
    else $error("irq b fell with no cause");
  a_rate_pulse_single: assert property (serial_rate_pulse |=> !serial_rate_pulse)
    else $error("rate pulse longer than one cycle");
endmodule // dtc_top_monitor

bind dtc_top dtc_top_monitor i_dtc_top_monitor (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .int_service_a(int_service_a), .int_service_b(int_service_b), .irq_a(irq_a),
  .irq_b(irq_b), .serial_rate_pulse(serial_rate_pulse));
`default_nettype wire

/* tb/dual_timer_counter_bench.sv */
// self-checking bench for the dual timer/counter
`timescale 1ns/10ps
`default_nettype none
`include "dtc_regs.svh"
module dual_timer_counter_bench;
  logic        clk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic        svc_a = 1'b0, svc_b = 1'b0, go = 1'b0;
  logic        wb_ack_o, irq_a, irq_b, serial_rate_pulse, pin_a, pin_b, gate_a, gate_b, busy;
  logic [1:0]  gate_lvl = 2'b00;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        rate_seen = 1'b0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  int          miscompares = 0, total_checks = 0;

  dtc_pin_model i_dtc_pin_model (.clk(clk), .go(go), .edges(8'h03), .gate_lvl(gate_lvl), .count_a(pin_a),
    .count_b(pin_b), .gate_a(gate_a), .gate_b(gate_b), .busy(busy));
  dtc_top i_dtc_top (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .count_pin_a(pin_a), .count_pin_b(pin_b), .ext_irq_a_pin(gate_a), .ext_irq_b_pin(gate_b),
    .int_service_a(svc_a), .int_service_b(svc_b), .irq_a(irq_a), .irq_b(irq_b),
    .serial_rate_pulse(serial_rate_pulse));

  // sticky record of any serial rate pulse
  always @(posedge clk)
    if (serial_rate_pulse === 1'b1)
      rate_seen <= 1'b1;

  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout;
    check(32'hdead, 32'h0);
    complete_run;
  endtask

  task automatic wb(input logic [9:0] idx, input logic we, input logic [7:0] wd);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      timeout;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    check(rd, {24'h0, exp});
  endtask

  task automatic wait_irq(input logic b);
    int n;
    n = 0;
    while ((b ? irq_b : irq_a) !== 1'b1 && n < 44)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 44)
      timeout;
  endtask

  task automatic svc(input logic b);
    svc_a <= !b;
    svc_b <= b;
    @(posedge clk);
    svc_a <= 1'b0;
    svc_b <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, b ? irq_b : irq_a}, 32'h0);
  endtask

  task automatic pins(input logic [1:0] g);
    int n;
    gate_lvl <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (busy && n < 400);
    if (n >= 400)
      timeout;
    repeat (3 * `DTC_PERIPH_DIV) @(posedge clk);
  endtask

  initial
  begin
    forever #25 clk = ~clk;
  end

  // rows: timer b, aux, mode, low preset, high preset, high after wrap
  logic [40:0] tab [4] = '{{1'b0, 8'h00, 8'h01, 8'hfe, 8'hff, 8'h00}, {1'b0, 8'h01, 8'h00, 8'h1f, 8'hff, 8'h00},
                           {1'b1, 8'h00, 8'h20, 8'hff, 8'hf0, 8'hf0}, {1'b1, 8'h02, 8'h10, 8'hf0, 8'hff, 8'h00}};
  logic [9:0]  regs [7] = '{`DTC_IDX_CTRL, `DTC_IDX_MODE, `DTC_IDX_A_LOW, `DTC_IDX_B_LOW, `DTC_IDX_A_HIGH,
                            `DTC_IDX_B_HIGH, `DTC_IDX_AUX};

  initial
  begin
    logic       b;
    logic [7:0] aux, m, lo, hi, eh;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd_chk(regs[i], 8'h00);
    rd_chk(10'h3ff, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      {b, aux, m, lo, hi, eh} = tab[i];
      wb(`DTC_IDX_AUX, 1'b1, aux);
      wb(`DTC_IDX_MODE, 1'b1, m);
      wb(b ? `DTC_IDX_B_HIGH : `DTC_IDX_A_HIGH, 1'b1, hi);
      wb(b ? `DTC_IDX_B_LOW : `DTC_IDX_A_LOW, 1'b1, lo);
      wb(`DTC_IDX_CTRL, 1'b1, b ? 8'h40 : 8'h10);
      wait_irq(b);
      wb(`DTC_IDX_CTRL, 1'b1, b ? 8'h80 : 8'h20);
      rd_chk(b ? `DTC_IDX_B_HIGH : `DTC_IDX_A_HIGH, eh);
      svc(b);
      rd_chk(`DTC_IDX_CTRL, 8'h00);
    end
    check({31'h0, rate_seen}, 32'h1);
    wb(`DTC_IDX_AUX, 1'b1, 8'h00);
    wb(`DTC_IDX_MODE, 1'b1, 8'h33);
    wb(`DTC_IDX_A_HIGH, 1'b1, 8'hff);
    wb(`DTC_IDX_A_LOW, 1'b1, 8'h00);
    wb(`DTC_IDX_B_LOW, 1'b1, 8'h77);
    wb(`DTC_IDX_CTRL, 1'b1, 8'h40);
    wait_irq(1'b1);
    wb(`DTC_IDX_CTRL, 1'b1, 8'h80);
    rd_chk(`DTC_IDX_A_LOW, 8'h00);
    rd_chk(`DTC_IDX_A_HIGH, 8'h00);
    rd_chk(`DTC_IDX_B_LOW, 8'h77);
    svc(1'b1);
    wb(`DTC_IDX_MODE, 1'b1, 8'h5d);
    rd_chk(`DTC_IDX_MODE, 8'h5d);
    wb(`DTC_IDX_A_LOW, 1'b1, 8'h00);
    wb(`DTC_IDX_B_LOW, 1'b1, 8'h00);
    wb(`DTC_IDX_CTRL, 1'b1, 8'h50);
    pins(2'b00);
    rd_chk(`DTC_IDX_A_LOW, 8'h00);
    rd_chk(`DTC_IDX_B_LOW, 8'h03);
    pins(2'b01);
    rd_chk(`DTC_IDX_A_LOW, 8'h03);
    rd_chk(`DTC_IDX_B_LOW, 8'h06);
    complete_run;
  end
endmodule // dual_timer_counter_bench
`default_nettype wire
